/* File: fxes_pkg.sv */
// Constants for the 100BASE-X error and status register bank.
// Assumes an AXI4-Lite master with 32-bit data, single clock, sync reset.
package fxes_pkg;
  localparam logic [7:0] OFF_RX_ERR_COUNT = 8'h24;
  localparam logic [7:0] OFF_EXT_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h44;
  localparam logic [7:0] OFF_LINK_CTRL = 8'h48;
  localparam int STATUS_W = 16;
  localparam int COUNT_W = 16;
  localparam int BIT_OVR = 11;
  localparam int BIT_LOCKED = 9;
  localparam int BIT_LINK = 8;
  localparam int BIT_RFAULT = 7;
  localparam int BIT_FCAR = 5;
  localparam int BIT_ESD = 4;
  localparam int BIT_RXERR = 3;
  localparam int BIT_TXERR = 2;
  localparam int BIT_LOCKERR = 1;
  localparam int BIT_MLT3 = 0;
  localparam int NUM_EV = 8;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [7:0] EV_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    EV_OVR, EV_FCAR, EV_ESD, EV_RXERR, EV_TXERR, EV_LOCKERR, EV_MLT3, EV_CNT
  } fxes_ev_t;
endpackage

/* File: fxes_sync.sv */
// Three-stage synchroniser for a vector of pin levels.
// Assumes inputs come from outside the CLOCK domain.
`timescale 1ns/1ps
`default_nettype none
module fxes_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_dout;
  always_comb begin
    next_dout = dout;
    if (s2 == s3) begin
      next_dout = s3;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule
`default_nettype wire

/* File: fxes_regs.sv */
// Status, latched error bits and receive error counter with AXI4-Lite slave.
// Assumes PHY event pins asynchronous; events are levels, edges count.
`timescale 1ns/1ps
`default_nettype none
module fxes_regs
  import fxes_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // PHY status levels
  input wire logic LOCKED,
  input wire logic LINK_GOOD,
  input wire logic REMOTE_FAULT,
  // PHY event levels
  input wire logic FIFO_OVR_UNDR,
  input wire logic FALSE_CARRIER,
  input wire logic END_OF_STREAM_DELIMITER_ERR,
  input wire logic INVALID_CODE_PKT,
  input wire logic TX_ERROR_CODE_PKT,
  input wire logic LOCK_LOST,
  input wire logic MLT3_ERR,
  input wire logic RX_ERR_PKT,
  // AXI4-Lite write
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Interrupt and control
  output logic IRQ,
  output logic LINK_RESTART
);
  logic [10:0] pins;
  logic [10:0] sync;
  logic [NUM_EV-1:0] ev_prev;
  logic [NUM_EV-1:0] ev_pulse;
  logic [NUM_EV-1:0] latch;
  logic [NUM_EV-1:0] next_latch;
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] next_count;
  logic [NUM_EV-1:0] irq_stat;
  logic [NUM_EV-1:0] next_irq_stat;
  logic [NUM_EV-1:0] irq_mask;
  logic [NUM_EV-1:0] next_irq_mask;
  logic link_ctrl;
  logic next_link_ctrl;
  logic [7:0] aw_addr;
  logic aw_full;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_full;
  logic next_aw_full;
  logic next_w_full;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic do_write;
  logic do_read;
  logic rd_status;
  logic rd_count;
  logic [STATUS_W-1:0] status_word;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFF_EXT_STATUS) || (a == OFF_RX_ERR_COUNT) ||
             (a == OFF_IRQ_STATUS) || (a == OFF_IRQ_MASK) || (a == OFF_LINK_CTRL);
  endfunction

  assign pins = {RX_ERR_PKT, MLT3_ERR, LOCK_LOST, TX_ERROR_CODE_PKT, INVALID_CODE_PKT,
                 END_OF_STREAM_DELIMITER_ERR, FALSE_CARRIER, FIFO_OVR_UNDR,
                 REMOTE_FAULT, LINK_GOOD, LOCKED};

  fxes_sync #(.W(11)) u_sync (
    .clk(CLOCK),
    .rst(RESET),
    .din(pins),
    .dout(sync)
  );

  // Rising edges of event levels
  assign ev_pulse = sync[10:3] & ~ev_prev;

  // Bus handshakes
  assign AWREADY = !aw_full && !BVALID;
  assign WREADY = !w_full && !BVALID;
  assign ARREADY = !RVALID;
  assign do_write = aw_full && w_full && !BVALID;
  assign do_read = ARVALID && ARREADY;
  assign rd_status = do_read && (ARADDR == OFF_EXT_STATUS);
  assign rd_count = do_read && (ARADDR == OFF_RX_ERR_COUNT);

  // Status word; reserved bits read zero
  always_comb begin
    status_word = '0;
    status_word[BIT_OVR] = sync[3];
    status_word[BIT_LOCKED] = sync[0];
    status_word[BIT_LINK] = sync[1];
    status_word[BIT_RFAULT] = sync[2];
    status_word[BIT_FCAR] = latch[EV_FCAR];
    status_word[BIT_ESD] = latch[EV_ESD];
    status_word[BIT_RXERR] = latch[EV_RXERR];
    status_word[BIT_TXERR] = latch[EV_TXERR];
    status_word[BIT_LOCKERR] = latch[EV_LOCKERR];
    status_word[BIT_MLT3] = latch[EV_MLT3];
  end

  // Latched bits: read clears, new event wins
  always_comb begin
    next_latch = latch;
    if (rd_status) begin
      next_latch = '0;
    end
    next_latch = next_latch | ev_pulse;
  end

  // Receive error counter
  always_comb begin
    next_count = count;
    if (rd_count) begin
      next_count = COUNT_RESET;
    end
    if (ev_pulse[EV_CNT] && next_count != COUNT_MAX) begin
      next_count = next_count + 16'h0001;
    end
  end

  // Interrupt status, mask, control
  always_comb begin
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    next_link_ctrl = 1'b0;
    if (do_write && w_strb[0]) begin
      if (aw_addr == OFF_IRQ_STATUS) begin
        next_irq_stat = irq_stat & ~w_data[NUM_EV-1:0];
      end
      if (aw_addr == OFF_IRQ_MASK) begin
        next_irq_mask = w_data[NUM_EV-1:0];
      end
      if (aw_addr == OFF_LINK_CTRL) begin
        next_link_ctrl = w_data[0];
      end
    end
    next_irq_stat = next_irq_stat | ev_pulse;
  end

  // Bus channel state
  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = BVALID;
    next_bresp = BRESP;
    next_rvalid = RVALID;
    next_rdata = RDATA;
    next_rresp = RRESP;
    if (AWVALID && AWREADY) begin
      next_aw_full = 1'b1;
      next_aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      next_w_full = 1'b1;
      next_w_data = WDATA;
      next_w_strb = WSTRB;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (BVALID && BREADY) begin
      next_bvalid = 1'b0;
    end
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rresp = mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
      case (ARADDR)
        OFF_EXT_STATUS: next_rdata = {16'h0000, status_word};
        OFF_RX_ERR_COUNT: next_rdata = {16'h0000, count};
        OFF_IRQ_STATUS: next_rdata = {24'h000000, irq_stat};
        OFF_IRQ_MASK: next_rdata = {24'h000000, irq_mask};
        default: next_rdata = 32'h00000000;
      endcase
    end else if (RVALID && RREADY) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ev_prev <= EV_RESET;
      latch <= EV_RESET;
      count <= COUNT_RESET;
      irq_stat <= EV_RESET;
      irq_mask <= EV_RESET;
      link_ctrl <= 1'b0;
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
      w_full <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= RESP_OKAY;
    end else begin
      ev_prev <= sync[10:3];
      latch <= next_latch;
      count <= next_count;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      link_ctrl <= next_link_ctrl;
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      BVALID <= next_bvalid;
      BRESP <= next_bresp;
      RVALID <= next_rvalid;
      RDATA <= next_rdata;
      RRESP <= next_rresp;
    end
  end

  assign IRQ = |(irq_stat & irq_mask);
  assign LINK_RESTART = link_ctrl;

  a_latch_holds: assert property (@(posedge CLOCK) disable iff (RESET)
    latch[EV_FCAR] && !rd_status |=> latch[EV_FCAR])
    else $error("false carrier latch dropped without read");
  a_event_sets: assert property (@(posedge CLOCK) disable iff (RESET)
    ev_pulse[EV_MLT3] |=> latch[EV_MLT3])
    else $error("mlt3 event not latched");
  a_read_clears: assert property (@(posedge CLOCK) disable iff (RESET)
    rd_status && !ev_pulse[EV_ESD] |=> !latch[EV_ESD])
    else $error("esd latch not cleared by read");
  a_read_race: assert property (@(posedge CLOCK) disable iff (RESET)
    rd_status && ev_pulse[EV_TXERR] |=> latch[EV_TXERR])
    else $error("event lost on clearing read");
  a_count_inc: assert property (@(posedge CLOCK) disable iff (RESET)
    ev_pulse[EV_CNT] && !rd_count && count != COUNT_MAX |=> count == $past(count) + 16'h0001)
    else $error("counter did not increment");
  a_count_sat: assert property (@(posedge CLOCK) disable iff (RESET)
    count == COUNT_MAX && !rd_count |=> count == COUNT_MAX)
    else $error("counter wrapped");
  a_count_clr: assert property (@(posedge CLOCK) disable iff (RESET)
    rd_count |=> count == {15'h0000, $past(ev_pulse[EV_CNT])})
    else $error("counter not cleared by read");
  a_live_lock: assert property (@(posedge CLOCK) disable iff (RESET)
    rd_status |=> RDATA[BIT_LOCKED] == $past(sync[0]) && RDATA[BIT_LINK] == $past(sync[1]))
    else $error("live lock or link bit wrong");
  a_fault_live: assert property (@(posedge CLOCK) disable iff (RESET)
    rd_status |=> RDATA[BIT_RFAULT] == $past(sync[2]) && RDATA[BIT_OVR] == $past(sync[3]))
    else $error("remote fault or fifo bit wrong");
  a_rx_bit: assert property (@(posedge CLOCK) disable iff (RESET)
    ev_pulse[EV_RXERR] ##1 rd_status |=> RDATA[BIT_RXERR])
    else $error("invalid code bit missing");

  // Latch and counter bookkeeping
  a_fcar_sets: assert property (@(posedge CLOCK) disable iff (RESET)
    ev_pulse[EV_FCAR] |=> latch[EV_FCAR])
    else $error("false carrier event not latched");
  a_esd_sets: assert property (@(posedge CLOCK) disable iff (RESET)
    ev_pulse[EV_ESD] |=> latch[EV_ESD])
    else $error("esd event not latched");
  a_rxerr_sets: assert property (@(posedge CLOCK) disable iff (RESET)
    ev_pulse[EV_RXERR] |=> latch[EV_RXERR])
    else $error("invalid code event not latched");
  a_txerr_sets: assert property (@(posedge CLOCK) disable iff (RESET)
    ev_pulse[EV_TXERR] |=> latch[EV_TXERR])
    else $error("transmit error event not latched");
  a_lockerr_sets: assert property (@(posedge CLOCK) disable iff (RESET)
    ev_pulse[EV_LOCKERR] |=> latch[EV_LOCKERR])
    else $error("lock loss event not latched");
  a_latch_quiet: assert property (@(posedge CLOCK) disable iff (RESET)
    !rd_status && ev_pulse == EV_RESET |=> latch == $past(latch))
    else $error("latched bits changed without event or read");
  a_read_clears_all: assert property (@(posedge CLOCK) disable iff (RESET)
    rd_status && ev_pulse == EV_RESET |=> latch == EV_RESET)
    else $error("status read left latched bits set");
  a_count_hold: assert property (@(posedge CLOCK) disable iff (RESET)
    !ev_pulse[EV_CNT] && !rd_count |=> count == $past(count))
    else $error("counter moved without event or read");
  a_count_rdata: assert property (@(posedge CLOCK) disable iff (RESET)
    rd_count |=> RDATA == {16'h0000, $past(count)})
    else $error("counter read returned wrong value");

  // Bus channel protocol, interrupt and link restart
  a_write_answer: assert property (@(posedge CLOCK) disable iff (RESET)
    AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("write response late");
  a_bvalid_hold: assert property (@(posedge CLOCK) disable iff (RESET)
    BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped before taken");
  a_bvalid_clear: assert property (@(posedge CLOCK) disable iff (RESET)
    BVALID && BREADY |=> !BVALID)
    else $error("write response not released");
  a_read_answer: assert property (@(posedge CLOCK) disable iff (RESET)
    ARVALID && ARREADY |=> RVALID)
    else $error("read data late");
  a_rvalid_hold: assert property (@(posedge CLOCK) disable iff (RESET)
    RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
    else $error("read data dropped before taken");
  a_rvalid_clear: assert property (@(posedge CLOCK) disable iff (RESET)
    RVALID && RREADY |=> !RVALID)
    else $error("read data not released");
  a_slverr_read: assert property (@(posedge CLOCK) disable iff (RESET)
    ARVALID && ARREADY && !mapped(ARADDR) |=> RRESP == RESP_SLVERR && RDATA == 32'h00000000)
    else $error("unmapped read not refused");
  a_irq_sets: assert property (@(posedge CLOCK) disable iff (RESET)
    ev_pulse[EV_FCAR] && irq_mask[EV_FCAR] && !do_write |=> IRQ)
    else $error("unmasked event did not raise interrupt");
  a_irq_ack: assert property (@(posedge CLOCK) disable iff (RESET)
    do_write && w_strb[0] && aw_addr == OFF_IRQ_STATUS && ev_pulse == EV_RESET
    |=> (irq_stat & $past(w_data[NUM_EV-1:0])) == EV_RESET)
    else $error("interrupt status not cleared by write");
  a_restart_pulse: assert property (@(posedge CLOCK) disable iff (RESET)
    LINK_RESTART |=> !LINK_RESTART)
    else $error("link restart longer than one cycle");
endmodule
`default_nettype wire

/* File: fxes_host.sv */
// Host model: AXI4-Lite master tasks for the status register bank.
// Assumes callers run on the rising edge of CLOCK.
`timescale 1ns/1ps
`default_nettype none
module fxes_host (
  // Clock
  input wire logic CLOCK,
  // Write channels
  output logic [7:0] AWADDR,
  output logic AWVALID,
  input wire logic AWREADY,
  output logic [31:0] WDATA,
  output logic [3:0] WSTRB,
  output logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  output logic BREADY,
  // Read channels
  output logic [7:0] ARADDR,
  output logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  output logic RREADY
);
  initial begin
    {AWADDR, AWVALID, WDATA, WSTRB, WVALID, BREADY} = '0;
    {ARADDR, ARVALID, RREADY} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge CLOCK);
    AWADDR <= a;
    AWVALID <= 1'b1;
    WDATA <= d; // Callers keep reserved bits at zero
    WSTRB <= 4'hf;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!done) begin
      @(posedge CLOCK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (BVALID) begin
        r = BRESP;
        BREADY <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!done) begin
      @(posedge CLOCK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RVALID) begin
        d = RDATA;
        r = RRESP;
        RREADY <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: fxes_regs_tb.sv */
// Testbench for the status register bank.
// Assumes the host model drives the register bus.
`timescale 1ns/1ps
`default_nettype none
module fxes_regs_tb;
  import fxes_pkg::*;
  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  logic [3:0] live = 4'h0;
  logic [6:0] ev = 7'h00;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, d;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, r;
  logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY, IRQ, LINK_RESTART;
  logic [25:0] rows [8];
  int err_count = 0;
  int num_checks = 0;
  int restarts = 0;
  always #20 CLOCK = ~CLOCK;
  always @(posedge CLOCK) if (LINK_RESTART === 1'b1) restarts++;
  fxes_regs uut (.CLOCK, .RESET, .LOCKED(live[2]), .LINK_GOOD(live[1]),
    .REMOTE_FAULT(live[0]), .FIFO_OVR_UNDR(live[3]), .FALSE_CARRIER(ev[5]),
    .END_OF_STREAM_DELIMITER_ERR(ev[4]), .INVALID_CODE_PKT(ev[3]),
    .TX_ERROR_CODE_PKT(ev[2]), .LOCK_LOST(ev[1]), .MLT3_ERR(ev[0]), .RX_ERR_PKT(ev[6]),
    .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID,
    .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .IRQ,
    .LINK_RESTART);
  fxes_host host (.CLOCK, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
    .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP,
    .RVALID, .RREADY);
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    repeat (4) @(posedge CLOCK);
    ev[i] <= 1'b0;
    repeat (6) @(posedge CLOCK);
  endtask
  task automatic race_read(input int i, input logic [7:0] a);
    ev[i] <= 1'b1;
    repeat (3) @(posedge CLOCK);
    host.rd(a, d, r);
    ev[i] <= 1'b0;
    repeat (6) @(posedge CLOCK);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLOCK);
    err_count++;
    give_verdict();
  end
  initial begin
    // Live pins, event pins, expected status
    rows = '{{4'h6, 6'h00, 16'h0300}, {4'h9, 6'h20, 16'h08a0}, {4'h0, 6'h10, 16'h0010},
      {4'h0, 6'h08, 16'h0008}, {4'h0, 6'h04, 16'h0004}, {4'h0, 6'h02, 16'h0002},
      {4'h0, 6'h01, 16'h0001}, {4'h4, 6'h3f, 16'h023f}};
    repeat (10) @(posedge CLOCK);
    RESET <= 1'b0;
    host.rd(OFF_RX_ERR_COUNT, d, r);
    check("count reset", d, 32'h0);
    host.rd(OFF_IRQ_MASK, d, r);
    check("mask reset", d, 32'h0);
    $display("reset values done");
    foreach (rows[i]) begin
      live <= rows[i][25:22];
      ev[5:0] <= rows[i][21:16];
      repeat (4) @(posedge CLOCK);
      ev[5:0] <= 6'h00;
      repeat (6) @(posedge CLOCK);
      host.rd(OFF_EXT_STATUS, d, r);
      check("status", d & 32'h0bbf, {16'h0, rows[i][15:0]});
      host.rd(OFF_EXT_STATUS, d, r);
      check("status reread", d & 32'h0bbf, {16'h0, rows[i][15:0] & 16'h0b80});
      check("irq idle", {31'h0, IRQ}, 32'h0);
      $display("row %0d done", i);
    end
    repeat (3) pulse(6);
    host.rd(OFF_RX_ERR_COUNT, d, r);
    check("count", d, 32'h3);
    host.rd(OFF_RX_ERR_COUNT, d, r);
    check("count cleared", d, 32'h0);
    host.wr(OFF_RX_ERR_COUNT, 32'h1234, r);
    check("count write resp", {30'h0, r}, {30'h0, RESP_OKAY});
    pulse(6);
    host.rd(OFF_RX_ERR_COUNT, d, r);
    check("count after write", d, 32'h1);
    host.rd(8'h10, d, r);
    check("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    check("unmapped data", d, 32'h0);
    $display("counter done");
    host.wr(OFF_IRQ_STATUS, 32'hff, r);
    host.rd(OFF_IRQ_STATUS, d, r);
    check("irq cleared", d, 32'h0);
    host.wr(OFF_IRQ_MASK, 32'h2, r);
    pulse(5);
    check("irq raised", {31'h0, IRQ}, 32'h1);
    host.rd(OFF_IRQ_STATUS, d, r);
    check("irq status", d, 32'h2);
    host.wr(OFF_IRQ_MASK, 32'h0, r);
    check("irq masked", {31'h0, IRQ}, 32'h0);
    host.wr(OFF_IRQ_MASK, 32'h2, r);
    check("irq unmasked", {31'h0, IRQ}, 32'h1);
    host.wr(OFF_IRQ_STATUS, 32'h2, r);
    check("irq acked", {31'h0, IRQ}, 32'h0);
    host.wr(OFF_LINK_CTRL, 32'h1, r);
    repeat (3) @(posedge CLOCK);
    check("restart pulses", restarts, 1);
    $display("irq and control done");
    race_read(2, OFF_EXT_STATUS);
    check("race status first", d & 32'h4, 32'h0);
    host.rd(OFF_EXT_STATUS, d, r);
    check("race status kept", d & 32'h4, 32'h4);
    race_read(6, OFF_RX_ERR_COUNT);
    check("race count first", d, 32'h0);
    host.rd(OFF_RX_ERR_COUNT, d, r);
    check("race count kept", d, 32'h1);
    $display("read race done");
    pulse(6);
    pulse(5);
    RESET <= 1'b1;
    repeat (2) @(posedge CLOCK);
    RESET <= 1'b0;
    host.rd(OFF_RX_ERR_COUNT, d, r);
    check("count after reset", d, 32'h0);
    host.rd(OFF_EXT_STATUS, d, r);
    check("latched after reset", d & 32'h3f, 32'h0);
    check("irq after reset", {31'h0, IRQ}, 32'h0);
    $display("mid-run reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
